// ---- rtl/sealer_defs.svh ----
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 250 MHz system clock, 1 ms timebase from a divider.
// Notes:   Included by the supervisory controller only.
//
// Operation
// - Unlocked manual key heats only while held
// - Locked manual key ignored in home position
// - Celsius default; Fahrenheit only at display
// - Unit change never disturbs running cycle
// - Menu held 2 s at power-up toggles lock
// - Opening locked configuration shows notice 5 s
// - Locked configuration readable, writes rejected; code rejects only CTRL writes
// - Lock persists until toggled; starts unlocked
// - Undervoltage: standby, no heat, no measuring
// - Voltage restored: leave standby, resume operation
// - Standby drives analog output to zero
// - Alarm replaces temperature with code voltage level
// - Setup errors alternate level and full scale 1 Hz
// - Start signal freezes the alternating output
// - Temperature mode times seal from 95 percent
// - Seal interval end stops heat, starts cooling
// - Start begins timeout, holds jaw relay
// - Absolute cooling holds relay until threshold reached
// - Faults show numeric error code on display
// - Alarm cleared only by reset key
// - Each error group has fixed output level
`ifndef SEALER_DEFS_SVH
`define SEALER_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_SET_TEMP  8'h04
`define OFS_SEAL_TIME 8'h08
`define OFS_COOL_VAL  8'h0C
`define OFS_STATUS    8'h10

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define CTRL_MANUAL_HEAT_KEY_LOCK  0
`define CTRL_UNIT_F     1
`define CTRL_TEMP_START 2
`define CTRL_ABS_COOL   3
`define RST_SET_TEMP    10'h0B4
`define RST_SEAL_MS     16'h03E8
`define RST_COOL_VAL    16'h0050

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   4
`define TICK_NS         1000000
`define T_LOCK_HOLD_MS  2000
`define T_LOCK_MSG_MS   2000
`define T_LOCKED_MSG_MS 5000
`define T_ALT_HALF_MS   500
`define REACH_PERCENT   95
`define DAC_STEP        68
`define DAC_FULL        10'h3FF

`endif

// ---- rtl/sealer_pkg.sv ----
// Purpose: Types shared by the supervisory controller.
// Assumes: Nothing beyond the defs header.
// Notes:   All module state travels as one packed struct.
package sealer_pkg;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DISP_HOME, DISP_STANDBY, DISP_ERROR,
    DISP_LOCK_ON, DISP_LOCK_OFF, DISP_LOCKED
  } disp_t;

  typedef enum logic [2:0] {
    CYC_IDLE, CYC_CLOSE, CYC_REACH, CYC_SEAL, CYC_COOL, CYC_DONE
  } cyc_t;

  // ----------------------------------------------------------------
  // Whole state of the controller
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] hrdata;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        manual_heat_key_lock;
    logic        unit_f;
    logic        temp_start;
    logic        abs_cool;
    logic [9:0]  set_temp;
    logic [15:0] seal_ms;
    logic [15:0] cool_val;
    logic        cfg_lock;
    logic [31:0] tick_cnt;
    logic        ms_tick;
    logic [12:0] menu_ms;
    logic        menu_done;
    logic [12:0] msg_ms;
    disp_t       msg;
    cyc_t        cyc;
    logic [15:0] cyc_ms;
    logic        start_q;
    logic        alarm;
    logic [9:0]  err_code;
    logic [9:0]  alt_ms;
    logic        alt_full;
    logic        alt_hold;
    logic        heat;
    logic        jaw;
    logic        meas_en;
    logic [9:0]  aout;
    disp_t       disp;
    logic [9:0]  disp_code;
    logic [10:0] disp_temp;
  } state_t;

endpackage : sealer_pkg

// ---- rtl/sealer_supervisory_control.sv ----
// Purpose: Supervisory logic of an impulse sealing temperature controller.
// Assumes: All inputs synchronous to MCLK; temperatures in Celsius.
// Notes:   AHB-Lite slave with zero wait states, always OKAY.
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "sealer_defs.svh"

module sealer_supervisory_control #(
  parameter int MS_CYCLES = `TICK_NS / `CLK_PERIOD_NS, // Cycles per ms
  parameter int TEMP_FS   = 300                       // Full scale in C
) (
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0]  HADDR,
  input  wire logic [1:0]   HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]   HSIZE,
  input  wire logic [31:0]  HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]       HRDATA,
  output logic              HREADYOUT,
  output logic              HRESP,
  // Operator and machine contacts
  input  wire logic        MANUAL_HEAT_KEY,
  input  wire logic        MENU_KEY,
  input  wire logic        RESET_KEY,
  input  wire logic        FOOT_SWITCH,
  input  wire logic        START,
  input  wire logic        HOME_POS,
  input  wire logic        POWERUP_MSG,
  input  wire logic        CFG_OPEN,
  input  wire logic        UNDERVOLT,
  input  wire logic [9:0]   ACT_TEMP,
  input  wire logic        FAULT,
  input  wire logic [9:0]   FAULT_CODE,
  // Actuators and indication
  output logic              HEAT,
  output logic              JAW_RELAY,
  output logic              MEAS_EN,
  output logic [9:0]        AOUT,
  output sealer_pkg::disp_t DISP_MSG,
  output logic [9:0]        DISP_CODE,
  output logic [10:0]       DISP_TEMP,
  output logic              CFG_LOCK
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Error code to output level index
  function automatic logic [3:0] level_idx(input logic [9:0] code);
    logic [3:0] idx;
    idx = 4'hD;
    if (code == 10'd101) begin
      idx = 4'h1;                       // Current missing
    end else if (code == 10'd102) begin
      idx = 4'h2;
    end else if (code == 10'd103) begin
      idx = 4'h3;                       // Both missing
    end else if (code >= 10'd307 && code <= 10'd310) begin
      idx = 4'h4;
    end else if (code >= 10'd201 && code <= 10'd203) begin
      idx = 4'h5;
    end else if (code >= 10'd800 && code <= 10'd899) begin
      idx = 4'h6;
    end else if (code >= 10'd900) begin
      idx = 4'h7;                       // Internal fault
    end else if (code >= 10'd104 && code <= 10'd106) begin
      idx = 4'h8;
    end else if (code >= 10'd111 && code <= 10'd114) begin
      idx = 4'h9;
    end else if (code == 10'd211) begin
      idx = 4'hA;
    end else if (code == 10'd107 || code == 10'd108) begin
      idx = 4'hB;
    end
    return idx;
  endfunction : level_idx

  // Codes that need calibration or point to bad setup
  function automatic logic alternating(input logic [9:0] code);
    return (code >= 10'd104 && code <= 10'd106) ||
           (code >= 10'd111 && code <= 10'd114) ||
           (code == 10'd211);
  endfunction : alternating

  // ----------------------------------------------------------------
  // State and combinational terms
  // ----------------------------------------------------------------
  sealer_pkg::state_t st;         // Registered state
  sealer_pkg::state_t next_st;    // Next state
  logic               addr_ph;    // Valid address phase
  logic [31:0]        rd_val;     // Read mux
  logic [16:0]        act_pct;    // Actual times 100
  logic [16:0]        set_pct;    // Set times percent
  logic [14:0]        dac_err;    // Error level before cut
  logic [19:0]        dac_temp;   // Scaled temperature
  logic [13:0]        f_temp;     // Fahrenheit intermediate
  logic               start_rise; // START edge
  logic               standby;    // Undervoltage active
  logic [15:0]        ms_lim;     // Seal time limit

  assign addr_ph    = HSEL && HREADY && HTRANS[1];
  assign start_rise = START && !st.start_q;
  assign standby    = UNDERVOLT;
  assign act_pct    = 17'(ACT_TEMP) * 17'd100;
  assign set_pct    = 17'(st.set_temp) * 17'(`REACH_PERCENT);
  assign dac_err    = 15'(level_idx(st.err_code)) * 15'(`DAC_STEP);
  assign dac_temp   = (20'(ACT_TEMP) * 20'h003FF) / 20'(TEMP_FS);
  assign f_temp     = (14'(ACT_TEMP) * 14'd9) / 14'd5 + 14'd32;
  assign ms_lim     = st.seal_ms;

  // Register read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (HADDR[7:0])
      `OFS_CTRL: begin
        rd_val[`CTRL_MANUAL_HEAT_KEY_LOCK]  = st.manual_heat_key_lock;
        rd_val[`CTRL_UNIT_F]     = st.unit_f;
        rd_val[`CTRL_TEMP_START] = st.temp_start;
        rd_val[`CTRL_ABS_COOL]   = st.abs_cool;
      end
      `OFS_SET_TEMP:  rd_val[9:0]  = st.set_temp;
      `OFS_SEAL_TIME: rd_val[15:0] = st.seal_ms;
      `OFS_COOL_VAL:  rd_val[15:0] = st.cool_val;
      `OFS_STATUS: begin
        rd_val[0]     = standby;
        rd_val[1]     = st.alarm;
        rd_val[2]     = st.cfg_lock;
        rd_val[3]     = st.heat;
        rd_val[4]     = st.jaw;
        rd_val[7:5]   = st.cyc;
        rd_val[25:16] = st.err_code;
      end
      default: rd_val = 32'h0000_0000;   // Unmapped reads zero
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.start_q = START;

    // 1 ms timebase divider
    next_st.ms_tick = 1'b0;
    if (st.tick_cnt >= 32'(MS_CYCLES - 1)) begin
      next_st.tick_cnt = 32'h0000_0000;
      next_st.ms_tick  = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 32'h0000_0001;
    end

    // Bus: read data captured in address phase
    if (addr_ph && !HWRITE) begin
      next_st.hrdata = rd_val;
    end
    next_st.wr_pend = addr_ph && HWRITE;
    next_st.wr_addr = HADDR[7:0];

    // Bus write data phase
    if (st.wr_pend) begin
      unique case (st.wr_addr)
        `OFS_CTRL: begin
          // Control fields are viewable but frozen when locked
          if (!st.cfg_lock) begin
            next_st.manual_heat_key_lock  = HWDATA[`CTRL_MANUAL_HEAT_KEY_LOCK];
            next_st.unit_f     = HWDATA[`CTRL_UNIT_F];
            next_st.temp_start = HWDATA[`CTRL_TEMP_START];
            next_st.abs_cool   = HWDATA[`CTRL_ABS_COOL];
          end
        end
        `OFS_SET_TEMP:  next_st.set_temp = HWDATA[9:0];
        `OFS_SEAL_TIME: next_st.seal_ms  = HWDATA[15:0];
        `OFS_COOL_VAL:  next_st.cool_val = HWDATA[15:0];
        default: ;                        // Status and holes ignore
      endcase
    end

    // Configuration lock toggle at power-up
    if (MENU_KEY && POWERUP_MSG) begin
      if (st.ms_tick && !st.menu_done) begin
        next_st.menu_ms = st.menu_ms + 13'd1;
      end
      if (!st.menu_done && st.menu_ms >= 13'(`T_LOCK_HOLD_MS)) begin
        next_st.cfg_lock  = !st.cfg_lock;
        next_st.menu_done = 1'b1;
        next_st.msg       = st.cfg_lock ? sealer_pkg::DISP_LOCK_OFF
                                        : sealer_pkg::DISP_LOCK_ON;
        next_st.msg_ms    = 13'(`T_LOCK_MSG_MS);
      end
    end else begin
      next_st.menu_ms   = 13'd0;
      next_st.menu_done = 1'b0;
    end

    // Notice when the locked menu is opened
    if (CFG_OPEN && st.cfg_lock) begin
      next_st.msg    = sealer_pkg::DISP_LOCKED;
      next_st.msg_ms = 13'(`T_LOCKED_MSG_MS);
    end else if (st.msg_ms != 13'd0 && st.ms_tick) begin
      next_st.msg_ms = st.msg_ms - 13'd1;
      if (st.msg_ms == 13'd1) begin
        next_st.msg = sealer_pkg::DISP_HOME;            // Back home
      end
    end

    // Alarm latch: only reset key clears; new fault wins
    if (FAULT) begin
      if (!st.alarm) begin
        next_st.err_code = FAULT_CODE;
        next_st.alt_ms   = 10'd0;
        next_st.alt_full = 1'b0;
        next_st.alt_hold = 1'b0;
      end
      next_st.alarm = 1'b1;
    end else if (RESET_KEY) begin
      next_st.alarm = 1'b0;
    end

    // 1 Hz alternation with equal halves
    if (st.alarm && alternating(st.err_code)) begin
      if (start_rise || START) begin
        next_st.alt_hold = 1'b1;
        next_st.alt_full = 1'b0;
      end else if (!st.alt_hold && st.ms_tick) begin
        if (st.alt_ms >= 10'(`T_ALT_HALF_MS - 1)) begin
          next_st.alt_ms   = 10'd0;
          next_st.alt_full = !st.alt_full;
        end else begin
          next_st.alt_ms = st.alt_ms + 10'd1;
        end
      end
    end

    // Sealing cycle sequencer
    if (st.ms_tick) begin
      next_st.cyc_ms = st.cyc_ms + 16'd1;
    end
    unique case (st.cyc)
      sealer_pkg::CYC_IDLE, sealer_pkg::CYC_CLOSE: begin
        next_st.cyc = FOOT_SWITCH ? sealer_pkg::CYC_CLOSE
                                  : sealer_pkg::CYC_IDLE;
        if (start_rise) begin
          next_st.cyc_ms = 16'd0;
          next_st.cyc    = st.temp_start ? sealer_pkg::CYC_REACH
                                         : sealer_pkg::CYC_SEAL;
        end
      end
      sealer_pkg::CYC_REACH: begin
        if (act_pct >= set_pct) begin
          next_st.cyc_ms = 16'd0;
          next_st.cyc    = sealer_pkg::CYC_SEAL;
        end
      end
      sealer_pkg::CYC_SEAL: begin
        if (st.cyc_ms >= ms_lim) begin
          next_st.cyc_ms = 16'd0;
          next_st.cyc    = sealer_pkg::CYC_COOL;
        end
      end
      sealer_pkg::CYC_COOL: begin
        if (st.abs_cool ? (ACT_TEMP <= st.cool_val[9:0])
                        : (st.cyc_ms >= st.cool_val)) begin
          next_st.cyc = sealer_pkg::CYC_DONE;
        end
      end
      sealer_pkg::CYC_DONE: begin
        // Start must drop before the next timeout
        if (!START) begin
          next_st.cyc = sealer_pkg::CYC_IDLE;
        end
      end
      default: next_st.cyc = sealer_pkg::CYC_IDLE;
    endcase
    // Standby or alarm abort any cycle
    if (standby || st.alarm) begin
      next_st.cyc = sealer_pkg::CYC_IDLE;
    end

    // Heater: cycle phases, else manual key at home
    next_st.heat = (st.cyc == sealer_pkg::CYC_REACH) ||
                   (st.cyc == sealer_pkg::CYC_SEAL);
    if (st.cyc == sealer_pkg::CYC_IDLE ||
        st.cyc == sealer_pkg::CYC_CLOSE) begin
      next_st.heat = HOME_POS && MANUAL_HEAT_KEY &&
                     !st.manual_heat_key_lock;
    end
    // Relay held through timing, cooling and done
    next_st.jaw = (st.cyc != sealer_pkg::CYC_IDLE);
    if (standby || st.alarm) begin
      next_st.heat = 1'b0;
      next_st.jaw  = 1'b0;
    end
    next_st.meas_en = !standby;

    // Analog output
    if (standby) begin
      next_st.aout = 10'h000;
    end else if (st.alarm) begin
      next_st.aout = st.alt_full ? `DAC_FULL
                                 : dac_err[9:0];
    end else if (dac_temp > 20'h003FF) begin
      next_st.aout = `DAC_FULL;
    end else begin
      next_st.aout = dac_temp[9:0];
    end

    // Display selection
    next_st.disp_code = st.err_code;
    if (st.alarm) begin
      next_st.disp = sealer_pkg::DISP_ERROR;
    end else if (standby) begin
      next_st.disp = sealer_pkg::DISP_STANDBY;
    end else begin
      next_st.disp = st.msg;
    end
    // Conversion only at the display boundary
    next_st.disp_temp = st.unit_f ? f_temp[10:0]
                                  : 11'(ACT_TEMP);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      st            <= '0;
      st.set_temp   <= `RST_SET_TEMP;
      st.seal_ms    <= `RST_SEAL_MS;
      st.cool_val   <= `RST_COOL_VAL;
      st.msg        <= sealer_pkg::DISP_HOME;
      st.disp       <= sealer_pkg::DISP_HOME;
      st.cyc        <= sealer_pkg::CYC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from flops; HREADYOUT and HRESP tied constant
  // ----------------------------------------------------------------
  assign HRDATA    = st.hrdata;
  assign HREADYOUT = 1'b1;               // Zero wait states
  assign HRESP     = 1'b0;               // Always OKAY
  assign HEAT      = st.heat;
  assign JAW_RELAY = st.jaw;
  assign MEAS_EN   = st.meas_en;
  assign AOUT      = st.aout;
  assign DISP_MSG  = st.disp;
  assign DISP_CODE = st.disp_code;
  assign DISP_TEMP = st.disp_temp;
  assign CFG_LOCK  = st.cfg_lock;

endmodule : sealer_supervisory_control

// ---- tb/machine_model.sv ----
// Purpose: Machine side: foot switch, start contact and band heat.
// Assumes: go asks for one sealing cycle; jaw is the relay output.
// Notes:   Band warms one degree per four clocks, cools one a clock.
`timescale 1ns/100ps
module machine_model (
  input  wire logic  mclk,
  input  wire logic  go,
  input  wire logic  heat,
  input  wire logic  jaw,
  output logic       foot,
  output logic       start,
  output logic [9:0] temp
);
  logic [1:0] ph = 2'h0; // Warm-up divider
  initial begin
    foot = 1'b0;
    start = 1'b0;
    temp = 10'h014;
  end
  // Slow warm-up keeps the band under set point during the seal
  always @(posedge mclk) begin
    ph <= ph + 2'h1;
    if (heat && ph == 2'h0) begin
      temp <= temp + 10'h001;
    end else if (!heat && temp > 10'h014) begin
      temp <= temp - 10'h001;
    end
  end
  // Close jaws, start once closed, let go of the foot switch
  always begin
    @(posedge mclk iff go);
    foot <= 1'b1;
    @(posedge mclk iff jaw);
    start <= 1'b1;
    repeat (4) @(posedge mclk);
    foot <= 1'b0;
    @(posedge mclk iff temp >= 10'h0AC);
    @(posedge mclk iff temp <= 10'h046);
    start <= 1'b0;
    @(posedge mclk iff !go);
  end
endmodule : machine_model

// ---- tb/sealer_checker.sv ----
// Purpose: Port assertions for the sealer supervisory control.
// Assumes: One clock MCLK; RESET asynchronous, active high.
// Notes:   Bound into the design; watches its ports only.
`timescale 1ns/100ps
module sealer_checker #(
  parameter int MS_CYCLES = 4 // Clocks per ms tick
) (
  input wire logic              MCLK,
  input wire logic              RESET,
  input wire logic              UNDERVOLT,
  input wire logic              RESET_KEY,
  input wire logic              START,
  input wire logic              FAULT,
  input wire logic [9:0]        FAULT_CODE,
  input wire logic              HEAT,
  input wire logic              MEAS_EN,
  input wire logic [9:0]        AOUT,
  input wire sealer_pkg::disp_t DISP_MSG,
  input wire logic [9:0]        DISP_CODE
);
  // ------------------------------------------------------------
  // Alternation timing helper
  // ------------------------------------------------------------
  localparam int HALF = 500 * MS_CYCLES; // Clocks in half a second
  logic [31:0] cnt;    // Clocks since AOUT last stepped
  logic [9:0]  aout_q; // AOUT one clock earlier
  logic        seen;   // Full-scale step seen
  logic        err;    // Error shown
  logic        chg;    // AOUT stepped
  assign err = DISP_MSG == sealer_pkg::DISP_ERROR;
  assign chg = AOUT != aout_q;
  // Only halves opened by a full-scale step are judged, since the
  // phase of the first half is arbitrary
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      cnt    <= 32'h0;
      aout_q <= 10'h000;
      seen   <= 1'b0;
    end else begin
      cnt    <= chg ? 32'h0 : cnt + 32'h1;
      aout_q <= AOUT;
      seen   <= err && !START && !RESET_KEY && !UNDERVOLT && (seen ||
                (chg && (AOUT == 10'h3FF || aout_q == 10'h3FF)));
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_meas; UNDERVOLT [*2] |=> !MEAS_EN; endproperty
  property p_heat; UNDERVOLT [*2] |=> !HEAT; endproperty
  property p_zero; UNDERVOLT [*2] |=> AOUT == 10'h000; endproperty
  property p_wake; (!UNDERVOLT) [*3] |=> MEAS_EN; endproperty
  property p_keep;
    err && !RESET_KEY && !$past(RESET_KEY) |=> err;
  endproperty
  property p_code;
    ($rose(FAULT) && !RESET_KEY && !err) ##1 !RESET_KEY
      |=> err && DISP_CODE == $past(FAULT_CODE, 2);
  endproperty
  property p_freeze;
    (START && err && !UNDERVOLT && !RESET_KEY) [*4] |=> $stable(AOUT);
  endproperty
  property p_alt;
    chg && seen && err |-> cnt >= HALF - 3 && cnt <= HALF + 1;
  endproperty
  a_meas: assert property (p_meas) else $error("measuring");
  a_heat: assert property (p_heat) else $error("heat on");
  a_zero: assert property (p_zero) else $error("output live");
  a_wake: assert property (p_wake) else $error("no resume");
  a_keep: assert property (p_keep) else $error("alarm lost");
  a_code: assert property (p_code) else $error("bad code");
  a_freeze: assert property (p_freeze) else $error("moving");
  a_alt: assert property (p_alt) else $error("bad half");
  c_alt: cover property (chg && seen && err);
  c_stby: cover property (UNDERVOLT [*2]);
  c_fault: cover property ($rose(FAULT));
endmodule : sealer_checker

bind sealer_supervisory_control sealer_checker #(
  .MS_CYCLES(MS_CYCLES)
) u_checker (
  .MCLK(MCLK), .RESET(RESET), .UNDERVOLT(UNDERVOLT),
  .RESET_KEY(RESET_KEY), .START(START), .FAULT(FAULT),
  .FAULT_CODE(FAULT_CODE), .HEAT(HEAT), .MEAS_EN(MEAS_EN),
  .AOUT(AOUT), .DISP_MSG(DISP_MSG), .DISP_CODE(DISP_CODE)
);

// ---- tb/test_sealer_supervisory_control.sv ----
// Purpose: Self-checking bench for the sealer supervisory control.
// Assumes: MS_CYCLES of 4, so one ms is four clocks.
// Notes:   Machine contacts and band temperature come from machine_model.
`timescale 1ns/100ps
module test_sealer_supervisory_control;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        mclk = 1'b0, reset = 1'b1, hsel = 1'b1, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        heat_key = 1'b0, menu_key = 1'b0, reset_key = 1'b0;
  logic        start_tb = 1'b0, powerup = 1'b0, cfg_open = 1'b0;
  logic        undervolt = 1'b0, fault = 1'b0, go = 1'b0;
  logic [9:0]  fault_code = 10'h000, act_temp, aout, disp_code;
  logic        hreadyout, foot, start, heat, jaw, meas_en, cfg_lock;
  logic [10:0] disp_temp;
  sealer_pkg::disp_t disp_msg;
  int          fail_count = 0, tests_run = 0, cycles = 0;
  sealer_supervisory_control #(.MS_CYCLES(4)) DUT (
    .MCLK(mclk), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(), .MANUAL_HEAT_KEY(heat_key), .MENU_KEY(menu_key),
    .RESET_KEY(reset_key), .FOOT_SWITCH(foot), .START(start | start_tb),
    .HOME_POS(1'b1), .POWERUP_MSG(powerup), .CFG_OPEN(cfg_open),
    .UNDERVOLT(undervolt), .ACT_TEMP(act_temp), .FAULT(fault),
    .FAULT_CODE(fault_code), .HEAT(heat), .JAW_RELAY(jaw),
    .MEAS_EN(meas_en), .AOUT(aout), .DISP_MSG(disp_msg),
    .DISP_CODE(disp_code), .DISP_TEMP(disp_temp), .CFG_LOCK(cfg_lock));
  machine_model machine (.mclk(mclk), .go(go), .heat(heat), .jaw(jaw),
    .foot(foot), .start(start), .temp(act_temp));
  always #2 mclk = ~mclk; // 250 MHz
  // Hang guard, well above the roughly 50k clocks the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 70000) begin
      fail_count++;
      conclude;
    end
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One AHB-Lite single word; read data taken at the data edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_basic;
    bus(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h0);
    chk(cfg_lock, 1'b0);
    bus(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0);
    chk(disp_temp, 11'h014);
    bus(1'b1, 8'h00, 32'h2, rd);
    tick(3);
    chk(disp_temp, 11'h044);
    bus(1'b1, 8'h00, 32'h0, rd);
    heat_key <= 1'b1;
    tick(3);
    chk(heat, 1'b1);
    heat_key <= 1'b0;
    tick(3);
    chk(heat, 1'b0);
    bus(1'b1, 8'h00, 32'h1, rd);
    heat_key <= 1'b1;
    tick(3);
    chk(heat, 1'b0);
    heat_key <= 1'b0;
    bus(1'b1, 8'h00, 32'h0, rd);
    $display("t_basic done");
  endtask : t_basic
  task automatic t_standby;
    undervolt <= 1'b1;
    heat_key <= 1'b1;
    tick(4);
    chk(disp_msg, sealer_pkg::DISP_STANDBY);
    chk({meas_en, heat, aout}, 12'h000);
    undervolt <= 1'b0;
    heat_key <= 1'b0;
    tick(4);
    chk({disp_msg, meas_en}, {sealer_pkg::DISP_HOME, 1'b1});
    $display("standby done");
  endtask : t_standby
  // Foot closes, start holds relay, seal from 95 percent, cool to 80
  task automatic t_cycle;
    int n;
    bus(1'b1, 8'h08, 32'h5, rd);
    bus(1'b1, 8'h00, 32'hC, rd);
    go <= 1'b1;
    for (n = 0; n < 3000 && act_temp < 10'h0AB; n++) @(posedge mclk);
    for (n = 0; n < 100 && heat === 1'b1; n++) @(posedge mclk);
    chk(n >= 14 && n <= 30, 1'b1);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk({rd[7:5], jaw}, {sealer_pkg::CYC_COOL, 1'b1});
    bus(1'b1, 8'h00, 32'hE, rd);
    chk(jaw, 1'b1);
    for (n = 0; n < 500 && act_temp > 10'h04F; n++) @(posedge mclk);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk({rd[7:5], jaw}, {sealer_pkg::CYC_DONE, 1'b1});
    for (n = 0; n < 100 && jaw === 1'b1; n++) @(posedge mclk);
    chk({jaw, start}, 2'h0);
    go <= 1'b0;
    bus(1'b1, 8'h00, 32'h0, rd);
    $display("cycle done");
  endtask : t_cycle
  task automatic t_alarm;
    logic [9:0] codes [3] = '{10'h065, 10'h067, 10'h0C9};
    logic [9:0] lvl [3] = '{10'h044, 10'h0CC, 10'h154};
    for (int i = 0; i < 4; i++) begin
      fault_code <= (i == 3) ? 10'h068 : codes[i];
      fault <= 1'b1;
      tick(2);
      fault <= 1'b0;
      tick(4);
      chk(disp_msg, sealer_pkg::DISP_ERROR);
      if (i < 3) begin
        chk({disp_code, aout}, {codes[i], lvl[i]});
        reset_key <= 1'b1;
        tick(2);
        reset_key <= 1'b0;
        tick(3);
        chk(disp_msg, sealer_pkg::DISP_HOME);
      end
    end
    tick(1000);
    rd = aout;
    tick(2000);
    chk(aout, rd == 32'h3FF ? 32'h220 : 32'h3FF);
    start_tb <= 1'b1;
    tick(10);
    chk(aout, 10'h220);
    tick(2500);
    chk(aout, 10'h220);
    start_tb <= 1'b0;
    reset_key <= 1'b1;
    tick(2);
    reset_key <= 1'b0;
    $display("alarm done");
  endtask : t_alarm
  task automatic t_lock;
    powerup <= 1'b1;
    menu_key <= 1'b1;
    tick(7900);
    chk(cfg_lock, 1'b0);
    tick(110);
    chk({cfg_lock, disp_msg}, {1'b1, sealer_pkg::DISP_LOCK_ON});
    powerup <= 1'b0;
    menu_key <= 1'b0;
    tick(7960);
    chk(disp_msg, sealer_pkg::DISP_LOCK_ON);
    tick(80);
    chk(disp_msg, sealer_pkg::DISP_HOME);
    bus(1'b1, 8'h00, 32'h1, rd);
    bus(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h0);
    cfg_open <= 1'b1;
    tick(3);
    cfg_open <= 1'b0;
    tick(19950);
    chk({cfg_lock, disp_msg}, {1'b1, sealer_pkg::DISP_LOCKED});
    tick(100);
    chk(disp_msg, sealer_pkg::DISP_HOME);
    powerup <= 1'b1;
    menu_key <= 1'b1;
    tick(8010);
    chk({cfg_lock, disp_msg}, {1'b0, sealer_pkg::DISP_LOCK_OFF});
    $display("lock done");
  endtask : t_lock
  initial begin
    tick(2);
    reset <= 1'b0;
    tick(1);
    t_basic;
    t_standby;
    t_cycle;
    t_alarm;
    t_lock;
    conclude;
  end
endmodule : test_sealer_supervisory_control
